// ### rtl/swdt_edge_sync.sv
`timescale 1ns/10ps
module swdt_edge_sync (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // asynchronous level in
    input wire logic async_in,
    // one-cycle pulse per agreed rising edge
    output logic rise_pulse
);
    logic ff1_reg;
    logic ff2_reg;
    logic ff3_reg;
    logic level_reg;
    wire agree = (ff2_reg == ff3_reg);
    wire level_next = agree ? ff3_reg : level_reg;

    // ff1 feeds only ff2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ff1_reg <= 1'b0;
            ff2_reg <= 1'b0;
            ff3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            ff1_reg <= async_in;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            level_reg <= level_next;
        end
    end

    assign rise_pulse = level_next & ~level_reg;
endmodule : swdt_edge_sync

// ### rtl/swdt_pkg.sv
package swdt_pkg;

    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] SWDT_OFF_CTRL = 8'h00;
    localparam logic [7:0] SWDT_OFF_STATUS = 8'h04;
    localparam logic [7:0] SWDT_OFF_MASK = 8'h08;
    localparam logic [7:0] SWDT_OFF_STATE = 8'h0c;
    localparam int SWDT_ADDR_W = 8;

    // watchdog_control field positions
    localparam int SWDT_CTRL_SRC_SEL = 7;
    localparam int SWDT_CTRL_STOP_RESET = 6;
    localparam int SWDT_CTRL_SRC_SEL2 = 5;
    localparam int SWDT_CTRL_CNT_HI = 4;
    localparam int SWDT_CTRL_CNT_LO = 0;

    // counter geometry
    localparam int SWDT_CNT_W = 8;
    localparam logic [SWDT_CNT_W-1:0] SWDT_CNT_RELOAD = 8'hff;
    localparam logic [SWDT_CNT_W-1:0] SWDT_CNT_ZERO = 8'h00;
    localparam int SWDT_CNT_TOP = 7;
    localparam int SWDT_CNT_BOT = 3;

    // slow interval: 32.768 ms at an 8 MHz main clock over 256 counts
    localparam longint SWDT_SLOW_INTERVAL_NS = 64'd32768000;
    localparam longint SWDT_MAIN_FREQ_KHZ = 64'd8000;
    localparam longint SWDT_SLOW_SRC_CYCLES = (SWDT_SLOW_INTERVAL_NS * SWDT_MAIN_FREQ_KHZ)
        / 64'd1000000;
    localparam longint SWDT_SLOW_DIV_L = SWDT_SLOW_SRC_CYCLES / 64'd256;
    localparam int SWDT_PRE_W = 10;
    localparam logic [SWDT_PRE_W-1:0] SWDT_SLOW_LAST = SWDT_PRE_W'(SWDT_SLOW_DIV_L - 64'd1);
    // fast divider used when the source select bit is set
    localparam logic [SWDT_PRE_W-1:0] SWDT_FAST_LAST = 10'h00f;
    localparam logic [SWDT_PRE_W-1:0] SWDT_PRE_ZERO = 10'h000;

    // sticky event bits
    localparam int SWDT_EV_W = 3;
    localparam int SWDT_EV_UNDERFLOW = 0;
    localparam int SWDT_EV_STOP_RESET = 1;
    localparam int SWDT_EV_LOCKED_WR = 2;
    localparam logic [SWDT_EV_W-1:0] SWDT_EV_NONE = 3'h0;

    // state register field positions
    localparam int SWDT_ST_CNT_LO = 0;
    localparam int SWDT_ST_CNT_HI = 7;
    localparam int SWDT_ST_RUN = 8;
    localparam int SWDT_ST_STOP = 9;
    localparam int SWDT_ST_LOCK = 10;
    localparam int SWDT_ST_WAIT = 11;

    localparam logic [1:0] SWDT_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] SWDT_HRESP_OKAY = 2'h0;

    typedef struct packed {
        logic src_sel;
        logic stop_reset;
        logic src_sel2;
    } swdt_ctrl_t;

    localparam swdt_ctrl_t SWDT_CTRL_RESET = '{src_sel: 1'b0, stop_reset: 1'b0, src_sel2: 1'b0};

    typedef enum logic [1:0] {
        SWDT_IDLE = 2'b00,
        SWDT_RUN = 2'b01,
        SWDT_HALT = 2'b10
    } swdt_state_t;

endpackage : swdt_pkg

// ### rtl/swdt_top.sv
// Summary of operation
// - one eight-bit down-counter forms the watchdog
// - reset and every control write load ff
// - bits seven to five written once after reset
// - stopped until first control write starts counting
// - underflow raises internal reset, cpu restarts at vector
// - read returns counter top five and select bits
// - stop bit clear: stop mode, resume after
// - wait instruction never halts the counter
// - stop bit set: stop causes reset, sticky
// - slow divider: 32.768 ms at 8 MHz
// - slow divider: 8.19 s on 32 kHz
// - counting continues through settle wait and wait
// - oscillator source forces oscillator running
// - any write strobe to control reloads
`timescale 1ns/10ps
module swdt_top
    import swdt_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // count sources from outside this clock domain
    input wire logic main_clock_input,
    input wire logic sub_clock_input,
    input wire logic osc_clock_input,
    input wire logic low_speed_mode,
    // cpu events, same clock domain
    input wire logic stop_instruction,
    input wire logic wait_instruction,
    input wire logic stop_release,
    input wire logic osc_stop_request,
    // chip control outputs
    output logic internal_reset,
    output logic stop_mode,
    output logic osc_run,
    output logic irq
);
    // bus address phase capture
    logic wr_pend_reg;
    logic [SWDT_ADDR_W-1:0] wr_addr_reg;
    logic [31:0] hrdata_reg;

    // watchdog state
    swdt_state_t state_reg;
    swdt_state_t state_next;
    logic [SWDT_CNT_W-1:0] cnt_reg;
    logic [SWDT_CNT_W-1:0] cnt_next;
    logic [SWDT_PRE_W-1:0] pre_reg;
    logic [SWDT_PRE_W-1:0] pre_next;
    swdt_ctrl_t ctrl_reg;
    swdt_ctrl_t ctrl_next;
    logic locked_reg;
    logic locked_next;
    logic rst_req_reg;
    logic rst_req_next;

    // interrupt registers
    logic [SWDT_EV_W-1:0] status_reg;
    logic [SWDT_EV_W-1:0] status_next;
    logic [SWDT_EV_W-1:0] mask_reg;
    logic [SWDT_EV_W-1:0] mask_next;

    // synchronised source edges
    logic main_rise;
    logic sub_rise;
    logic osc_rise;

    swdt_edge_sync u_sync_main (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(main_clock_input),
        .rise_pulse(main_rise)
    );

    swdt_edge_sync u_sync_sub (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(sub_clock_input),
        .rise_pulse(sub_rise)
    );

    swdt_edge_sync u_sync_osc (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(osc_clock_input),
        .rise_pulse(osc_rise)
    );

    // address decode; only whole-word transfers are expected
    wire bus_take = hsel & hready & (htrans == SWDT_HTRANS_NONSEQ);
    wire [SWDT_ADDR_W-1:0] addr_now = haddr[SWDT_ADDR_W-1:0];
    wire take_wr = bus_take & hwrite;
    wire take_rd = bus_take & ~hwrite;
    wire rd_ctrl = take_rd & (addr_now == SWDT_OFF_CTRL);
    wire rd_status = take_rd & (addr_now == SWDT_OFF_STATUS);
    wire rd_mask = take_rd & (addr_now == SWDT_OFF_MASK);
    wire rd_state = take_rd & (addr_now == SWDT_OFF_STATE);

    // write data phase strobes
    wire wr_ctrl = wr_pend_reg & (wr_addr_reg == SWDT_OFF_CTRL);
    wire wr_mask = wr_pend_reg & (wr_addr_reg == SWDT_OFF_MASK);
    wire first_wr = wr_ctrl & ~locked_reg;
    wire late_wr = wr_ctrl & locked_reg;

    // count source; the slow divider gives both documented intervals
    wire base_rise = low_speed_mode ? sub_rise : main_rise;
    wire src_rise = ctrl_reg.src_sel2 ? osc_rise : base_rise;
    wire [SWDT_PRE_W-1:0] pre_last = ctrl_reg.src_sel ? SWDT_FAST_LAST : SWDT_SLOW_LAST;
    wire pre_wrap = (pre_reg == pre_last);
    // counting goes on in wait and during settle time; only the run state counts, so stop mode and idle halt it
    wire counting = (state_reg == SWDT_RUN);
    wire cnt_tick = counting & src_rise & pre_wrap;
    wire underflow = cnt_tick & (cnt_reg == SWDT_CNT_ZERO);

    // stop instruction handling
    wire stop_taken = stop_instruction & (state_reg == SWDT_RUN || state_reg == SWDT_IDLE);
    wire stop_to_reset = stop_taken & ctrl_reg.stop_reset;
    wire stop_to_halt = stop_taken & ~ctrl_reg.stop_reset;
    wire chip_reset = underflow | stop_to_reset;

    // prescaler
    always_comb begin
        pre_next = pre_reg;
        if (wr_ctrl || chip_reset || !counting) begin
            pre_next = SWDT_PRE_ZERO;
        end else if (src_rise) begin
            pre_next = pre_wrap ? SWDT_PRE_ZERO : pre_reg + 10'h001;
        end
    end

    // counter; any control write reloads, whatever the data
    always_comb begin
        cnt_next = cnt_reg;
        if (wr_ctrl || chip_reset) begin
            cnt_next = SWDT_CNT_RELOAD;
        end else if (cnt_tick) begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    // write-once select bits; later writes reload and set the locked-write event
    always_comb begin
        ctrl_next = ctrl_reg;
        locked_next = locked_reg;
        if (chip_reset) begin
            ctrl_next = SWDT_CTRL_RESET;
            locked_next = 1'b0;
        end else if (first_wr) begin
            ctrl_next.src_sel = hwdata[SWDT_CTRL_SRC_SEL];
            ctrl_next.stop_reset = hwdata[SWDT_CTRL_STOP_RESET];
            ctrl_next.src_sel2 = hwdata[SWDT_CTRL_SRC_SEL2];
            locked_next = 1'b1;
        end
    end

    // run state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SWDT_IDLE: begin
                if (stop_to_halt) begin
                    state_next = SWDT_HALT;
                end else if (wr_ctrl) begin
                    state_next = SWDT_RUN;
                end
            end
            SWDT_RUN: begin
                if (chip_reset) begin
                    state_next = SWDT_IDLE;
                end else if (stop_to_halt) begin
                    state_next = SWDT_HALT;
                end
            end
            SWDT_HALT: begin
                // a watchdog that never started comes back still idle
                if (stop_release) begin
                    state_next = locked_reg ? SWDT_RUN : SWDT_IDLE;
                end
            end
            default: begin
                state_next = SWDT_IDLE;
            end
        endcase
        if (stop_to_reset) begin
            state_next = SWDT_IDLE;
        end
    end

    // one request per event; the cpu side stretches it and refetches the vector
    assign rst_req_next = chip_reset;

    // sticky events, set wins over read clear
    wire [SWDT_EV_W-1:0] ev_set = {late_wr, stop_to_reset, underflow};
    assign status_next = (rd_status ? SWDT_EV_NONE : status_reg) | ev_set;
    assign mask_next = wr_mask ? hwdata[SWDT_EV_W-1:0] : mask_reg;

    // read data, captured at the address phase edge
    wire [7:0] ctrl_view = {ctrl_reg.src_sel, ctrl_reg.stop_reset, ctrl_reg.src_sel2,
        cnt_reg[SWDT_CNT_TOP:SWDT_CNT_BOT]};
    wire [31:0] state_view = {20'h00000, wait_instruction, locked_reg,
        (state_reg == SWDT_HALT), counting, cnt_reg};
    wire [31:0] rd_word = rd_ctrl ? {24'h000000, ctrl_view} :
        rd_status ? {29'h00000000, status_reg} :
        rd_mask ? {29'h00000000, mask_reg} :
        rd_state ? state_view : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= take_wr;
            wr_addr_reg <= addr_now;
            hrdata_reg <= rd_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= SWDT_IDLE;
            cnt_reg <= SWDT_CNT_RELOAD;
            pre_reg <= SWDT_PRE_ZERO;
            ctrl_reg <= SWDT_CTRL_RESET;
            locked_reg <= 1'b0;
            rst_req_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
            ctrl_reg <= ctrl_next;
            locked_reg <= locked_next;
            rst_req_reg <= rst_req_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= SWDT_EV_NONE;
            mask_reg <= SWDT_EV_NONE;
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    // outputs
    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = SWDT_HRESP_OKAY[0];
    assign internal_reset = rst_req_reg;
    assign stop_mode = (state_reg == SWDT_HALT);
    // oscillator stop requests lose while it is the count source
    assign osc_run = ctrl_reg.src_sel2 | ~osc_stop_request;
    assign irq = |(status_reg & mask_reg);

endmodule : swdt_top

// ### verif/swdt_checker.sv
`timescale 1ns/10ps
module swdt_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus request
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // cpu events
    input wire logic stop_instruction,
    input wire logic stop_release,
    input wire logic osc_stop_request,
    // chip control
    input wire logic internal_reset,
    input wire logic stop_mode,
    input wire logic osc_run
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // any write arms; permissive on purpose, a write elsewhere only loses checking
    logic armed_reg;
    wire wr_seen = hsel & hready & htrans[1] & hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) armed_reg <= 1'b0;
        else armed_reg <= (armed_reg & ~internal_reset) | wr_seen;
    end
    chk_reset_single: assert property (internal_reset |=> !internal_reset)
        else $error("watchdog reset longer than one cycle");
    chk_idle_quiet: assert property (!armed_reg |-> !internal_reset)
        else $error("watchdog reset before any start");
    chk_osc_forced: assert property (!osc_stop_request |-> osc_run)
        else $error("oscillator stopped without request");
    chk_stop_acts: assert property (stop_instruction && !stop_mode
        |-> ##[1:2] (stop_mode || internal_reset)) else $error("stop had no effect");
    chk_halt_cause: assert property ($rose(stop_mode) |-> $past(stop_instruction))
        else $error("halt without stop");
    chk_halt_holds: assert property (stop_mode && !stop_release |=> stop_mode)
        else $error("halt left without release");
    chk_reset_awake: assert property (internal_reset |-> !stop_mode)
        else $error("watchdog reset while halted");
    chk_read_upper: assert property (hrdata[31:12] == 20'h0)
        else $error("upper read data not zero");
    cover property (internal_reset);
    cover property ($rose(stop_mode));
    cover property (osc_run && osc_stop_request);
endmodule : swdt_checker

bind swdt_top swdt_checker swdt_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .stop_instruction(stop_instruction), .stop_release(stop_release),
    .osc_stop_request(osc_stop_request), .internal_reset(internal_reset),
    .stop_mode(stop_mode), .osc_run(osc_run));

// ### verif/test_software_watchdog_timer.sv
`timescale 1ns/10ps
module test_software_watchdog_timer;
    import swdt_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic main_clock_input = 1'b0, sub_clock_input = 1'b0, low_speed_mode = 1'b0;
    logic osc_clock_input = 1'b0;
    logic stop_instruction = 1'b0, wait_instruction = 1'b0, stop_release = 1'b0;
    logic osc_stop_request = 1'b0, hreadyout, hresp, internal_reset, stop_mode, osc_run, irq;
    integer bad_count = 0, checks = 0, cycles = 0, rst_seen = 0, seed = 32'hd3c20d49;
    integer src_sub = 0, m_cnt, m_pre, m_div, m_run, m_halt, m_lock, m_ctrl, m_rst, m_stat;

    swdt_top swdt_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .main_clock_input(main_clock_input), .sub_clock_input(sub_clock_input),
        .osc_clock_input(osc_clock_input), .low_speed_mode(low_speed_mode),
        .stop_instruction(stop_instruction), .wait_instruction(wait_instruction),
        .stop_release(stop_release), .osc_stop_request(osc_stop_request),
        .internal_reset(internal_reset), .stop_mode(stop_mode), .osc_run(osc_run), .irq(irq));

    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (internal_reset === 1'b1) rst_seen <= rst_seen + 1;
        if (cycles == 60000) begin
            bad_count++;
            close_out();
        end
    end

    task close_out;
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one bus cycle phase; waits for ready at an edge, data taken there
    task ack;
        logic ok;
        do begin
            @(posedge hclk);
            ok = hreadyout;
            rd = hrdata;
        end while (ok !== 1'b1);
    endtask : ack
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= SWDT_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        ack();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        ack();
    endtask : bus
    task m_init;
        {m_cnt, m_pre, m_run, m_halt, m_lock, m_ctrl, m_div} = {32'd255, 160'd0, 32'd1024};
    endtask : m_init
    task wr_ctrl(input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        bus(1'b1, SWDT_OFF_CTRL, {r[31:8], d});
        if (m_lock) m_stat = m_stat | 4;
        else m_ctrl = d[7:5];
        {m_cnt, m_pre, m_run, m_lock} = {32'd255, 32'd0, 32'd1, 32'd1};
        m_div = m_ctrl[2] ? 16 : 1024;
    endtask : wr_ctrl
    task rd_ctrl;
        bus(1'b0, SWDT_OFF_CTRL, 32'h0);
        chk(rd, {m_ctrl[2:0], m_cnt[7:3]});
        chk({hreadyout, hresp}, 2'b10);
    endtask : rd_ctrl
    task rd_state;
        bus(1'b0, SWDT_OFF_STATE, 32'h0);
        chk({rd[10], rd[7:0]}, {m_lock[0], m_cnt[7:0]});
    endtask : rd_state
    task rd_status;
        bus(1'b0, SWDT_OFF_STATUS, 32'h0);
        chk(rd, m_stat);
        m_stat = 0;
    endtask : rd_status
    // slow enough for the three-stage synchroniser: four cycles high, four low
    task pulses(input integer n);
        repeat (n) begin
            if (m_ctrl[0]) osc_clock_input <= 1'b1;
            else if (src_sub) sub_clock_input <= 1'b1;
            else main_clock_input <= 1'b1;
            repeat (4) @(posedge hclk);
            {osc_clock_input, sub_clock_input, main_clock_input} <= 3'b000;
            repeat (4) @(posedge hclk);
            if (m_run && !m_halt) begin
                m_pre++;
                if (m_pre == m_div) begin
                    m_pre = 0;
                    if (m_cnt == 0) begin
                        m_rst++;
                        m_stat = m_stat | 1;
                        m_init();
                    end else m_cnt--;
                end
            end
        end
    endtask : pulses
    task stop_pulse;
        stop_instruction <= 1'b1;
        @(posedge hclk);
        stop_instruction <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask : stop_pulse

    initial begin
        m_init();
        {m_rst, m_stat} = 64'd0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_ctrl();
        pulses(32);
        rd_state();
        osc_stop_request <= 1'b1;
        wr_ctrl(8'h80);
        chk(osc_run, 1'b0);
        wr_ctrl(8'h60);
        rd_ctrl();
        rd_status();
        chk(irq, 1'b0);
        wait_instruction <= 1'b1;
        pulses(48);
        rd_state();
        stop_pulse();
        m_halt = 1;
        chk(stop_mode, 1'b1);
        pulses(32);
        rd_state();
        stop_release <= 1'b1;
        @(posedge hclk);
        stop_release <= 1'b0;
        m_halt = 0;
        @(posedge hclk);
        chk(stop_mode, 1'b0);
        pulses(16);
        rd_state();
        bus(1'b1, SWDT_OFF_MASK, 32'h1);
        bus(1'b0, SWDT_OFF_MASK, 32'h0);
        chk(rd, 32'h1);
        wr_ctrl(8'($random(seed)));
        chk(irq, 1'b0);
        pulses(4095);
        chk(rst_seen, m_rst);
        pulses(1);
        chk(rst_seen, m_rst);
        chk(irq, 1'b1);
        rd_status();
        chk(irq, 1'b0);
        rd_ctrl();
        wr_ctrl(8'he0);
        @(posedge hclk);
        chk(osc_run, 1'b1);
        pulses(16);
        rd_state();
        stop_pulse();
        m_rst++;
        m_stat = m_stat | 2;
        m_init();
        chk(rst_seen, m_rst);
        rd_status();
        rd_ctrl();
        low_speed_mode <= 1'b1;
        wait_instruction <= 1'b0;
        src_sub = 1;
        wr_ctrl(8'h1f);
        pulses(1023);
        rd_state();
        pulses(1);
        rd_state();
        close_out();
    end
endmodule : test_software_watchdog_timer
